// [src/lcdhp_port.sv]
`timescale 1ns/10ps
`include "lcdhp_map.svh"
// Operation
// - straps and bus status caught at reset release fix the bus mode
// - endian strap 0 gives little-endian, 1 gives big-endian
// - mode codes 000,001,011,101,111 decoded; 111 split by bus status; others reserved
// - each access stretched by a variable number of wait states
// - select covers a 128K-byte window of buffer and registers
// - registers in the top 32 bytes, 80K buffer from the window base
// - generic mode: byte write and read enables qualify low and high bytes
// - wait held until read data ready or write data accepted
module lcdhp_port
   import lcdhp_pkg::*;
(
   input  wire logic        CLK,                 // host bus clock, 100 MHz
   input  wire logic        RST_N,               // async reset, active low
   input  wire logic [2:0]  MODE_STRAP,          // mode straps {bit2,bit1,bit0}
   input  wire logic        ENDIAN_STRAP,        // endian strap
   input  wire logic        BUS_STATUS_N,        // address strobe / strap
   input  wire logic        CHIP_SELECT_N,       // device select
   input  wire logic [16:0] ADDR,                // byte address in window
   input  wire logic        HIGH_BYTE_WRITE_N,   // high byte enable / write
   input  wire logic        LOW_BYTE_WRITE_N,    // low byte write (generic)
   input  wire logic        LOW_BYTE_READ_N,     // low byte read (generic)
   input  wire logic        READ_WRITE,          // r/w or high byte read
   input  wire logic [15:0] DATA_IN,             // host write data
   input  wire logic        REFRESH_BUSY,        // display refresh holds memory
   output logic [15:0]      DATA_OUT,            // host read data
   output logic             DATA_OE,             // data bus drive enable
   output logic             WAIT_N,              // wait, active low
   output logic             WAIT_OE,             // wait drive enable
   output logic [2:0]       BUS_MODE,            // latched bus mode
   output logic             BIG_ENDIAN,          // latched byte order
   output logic             MODE_RESERVED        // straps gave a reserved code
);
   // top bit of the buffer word index taken from the host address
   localparam int BUF_W = 15;

   lcdhp_strap_type strap_meta, strap_sync;
   logic [3:0]      bus_meta, bus_sync;      // {cs_n, bs_n, lo_we_n, lo_rd_n}
   logic [2:0]      strb_meta, strb_sync;    // {hi_n, ab0, rw}
   lcdhp_cfg_type   cfg;
   logic            cfg_valid;
   logic [`LCDHP_CNT_W-1:0] wait_cnt;
   logic            busy;
   logic            done;
   logic [15:0]     regs [`LCDHP_REG_WORDS];
   logic [15:0]     buf_word [`LCDHP_BUF_WORDS];
   logic            acc_lo, acc_hi, acc_wr, acc_req;
   logic            strobe_mode;
   logic [16:0]     addr_meta, addr_sync;    // host address, synchronised
   logic [15:0]     din_meta, din_sync;      // host write data, synchronised
   logic            finish;                  // access completes on this edge
   logic [15:0]     wr_word;                 // write data in buffer byte order
   logic [15:0]     rd_word;                 // addressed word in host byte order

   // two-flop synchronisers on the host bus pins
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         bus_meta  <= 4'hf;
         bus_sync  <= 4'hf;
         strb_meta <= 3'h7;
         strb_sync <= 3'h7;
         addr_meta <= '0;
         addr_sync <= '0;
         din_meta  <= '0;
         din_sync  <= '0;
      end else begin
         bus_meta  <= {CHIP_SELECT_N, BUS_STATUS_N, LOW_BYTE_WRITE_N, LOW_BYTE_READ_N};
         bus_sync  <= bus_meta;
         strb_meta <= {HIGH_BYTE_WRITE_N, ADDR[0], READ_WRITE};
         strb_sync <= strb_meta;
         addr_meta <= ADDR;
         addr_sync <= addr_meta;
         din_meta  <= DATA_IN;
         din_sync  <= din_meta;
      end
   end

   // strap synchroniser runs through reset, so the first edge after release
   // captures the levels that stood while reset was low, never a reset value
   always_ff @(posedge CLK) begin
      strap_meta <= '{mode_strap: MODE_STRAP, endian_strap: ENDIAN_STRAP, bus_status_n: BUS_STATUS_N};
      strap_sync <= strap_meta;
   end

   // strap capture, held until the next reset
   lcdhp_strap u_strap (
      .clk       (CLK),
      .rst_n     (RST_N),
      .straps    (strap_sync),
      .cfg       (cfg),
      .cfg_valid (cfg_valid)
   );

   function automatic logic in_regs(input logic [16:0] a);
      in_regs = (a >= `LCDHP_REG_BASE);
   endfunction

   function automatic logic in_buf(input logic [16:0] a);
      in_buf = (a < `LCDHP_BUF_TOP);
   endfunction

   // big-endian hosts see the two byte lanes swapped
   function automatic logic [15:0] order_bytes(input logic [15:0] w, input logic big);
      order_bytes = big ? {w[7:0], w[15:8]} : w;
   endfunction

   // register word within the top 32 bytes of the window
   function automatic logic [`LCDHP_REG_IDX_W-1:0] reg_idx(input logic [16:0] a);
      reg_idx = a[`LCDHP_REG_IDX_W:1];
   endfunction

   // buffer word counted from the window base
   function automatic logic [BUF_W:0] buf_idx(input logic [16:0] a);
      buf_idx = a[BUF_W+1:1];
   endfunction

   // byte lanes and direction per mode
   always_comb begin
      strobe_mode = (cfg.mode == LCDHP_MODE_STROBE) || (cfg.mode == LCDHP_MODE_M68K2);
      if (strobe_mode) begin
         acc_lo  = !strb_sync[1];
         acc_hi  = !strb_sync[2];
         acc_wr  = !strb_sync[0];
         acc_req = !bus_sync[3] && !bus_sync[2] && (acc_lo || acc_hi);
      end else begin
         acc_wr  = !bus_sync[1] || !strb_sync[2];
         acc_lo  = acc_wr ? !bus_sync[1] : !bus_sync[0];
         acc_hi  = acc_wr ? !strb_sync[2] : !strb_sync[0];
         acc_req = !bus_sync[3] && (acc_lo || acc_hi);
      end
   end

   // wait counter: base delay plus panel-dependent extra while refresh busy
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wait_cnt <= '0;
         busy     <= 1'b0;
         done     <= 1'b0;
      end else if (bus_sync[3] || !cfg_valid) begin
         wait_cnt <= '0;
         busy     <= 1'b0;
         done     <= 1'b0;
      end else if (acc_req && !busy && !done) begin
         wait_cnt <= REFRESH_BUSY ? `LCDHP_CNT_W'(`LCDHP_WAIT_BASE + `LCDHP_WAIT_PANEL) : `LCDHP_WAIT_BASE;
         busy     <= 1'b1;
      end else if (busy && REFRESH_BUSY) begin
         wait_cnt <= wait_cnt;
      end else if (busy && wait_cnt != '0) begin
         wait_cnt <= wait_cnt - 1'b1;
      end else if (busy) begin
         busy <= 1'b0;
         done <= 1'b1;
      end
   end

   // an access completes once its count has run out and refresh has let go
   assign finish = busy && !REFRESH_BUSY && (wait_cnt == '0);

   // write data turned into buffer byte order
   assign wr_word = order_bytes(din_sync, cfg.big_endian);

   // addressed word in host byte order; outside buffer and registers reads as zero
   always_comb begin
      rd_word = 16'h0000;
      if (in_regs(addr_sync)) begin
         rd_word = order_bytes(regs[reg_idx(addr_sync)], cfg.big_endian);
      end else if (in_buf(addr_sync)) begin
         rd_word = order_bytes(buf_word[buf_idx(addr_sync)], cfg.big_endian);
      end
   end

   // register and buffer writes at completion, each byte lane under its own enable
   always_ff @(posedge CLK) begin
      if (finish && acc_wr) begin
         if (in_regs(addr_sync)) begin
            if (acc_lo) regs[reg_idx(addr_sync)][7:0]  <= wr_word[7:0];
            if (acc_hi) regs[reg_idx(addr_sync)][15:8] <= wr_word[15:8];
         end else if (in_buf(addr_sync)) begin
            if (acc_lo) buf_word[buf_idx(addr_sync)][7:0]  <= wr_word[7:0];
            if (acc_hi) buf_word[buf_idx(addr_sync)][15:8] <= wr_word[15:8];
         end
      end
   end

   // read data, wait and enables, all registered
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         DATA_OUT <= 16'h0000;
         DATA_OE  <= 1'b0;
         WAIT_N   <= 1'b1;
         WAIT_OE  <= 1'b0;
      end else begin
         WAIT_OE <= !bus_sync[3] && cfg_valid;
         WAIT_N  <= !(acc_req && !done && !bus_sync[3]) || !cfg_valid;
         DATA_OE <= !bus_sync[3] && !acc_wr && done;
         if (finish && !acc_wr) begin
            DATA_OUT <= rd_word;
         end
      end
   end

   // latched configuration outputs
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         BUS_MODE      <= 3'h0;
         BIG_ENDIAN    <= 1'b0;
         MODE_RESERVED <= 1'b0;
      end else begin
         BUS_MODE      <= cfg.mode;
         BIG_ENDIAN    <= cfg.big_endian;
         MODE_RESERVED <= cfg_valid && (cfg.mode == LCDHP_MODE_RESERVED);
      end
   end
endmodule

// [src/lcdhp_map.svh]
`ifndef LCDHP_MAP_SVH
`define LCDHP_MAP_SVH
// host address width: 128K-byte window, 17 byte-address bits
`define LCDHP_ADDR_W      17
// control registers occupy the top 32 bytes of the window
`define LCDHP_REG_BASE    17'h1ffe0
`define LCDHP_REG_WORDS   16
`define LCDHP_REG_IDX_W   4
// display buffer: 80K bytes from the window base, as 16-bit words
`define LCDHP_BUF_TOP     17'h14000
`define LCDHP_BUF_WORDS   40960
// mode strap codes {bit2,bit1,bit0}
`define LCDHP_CODE_HOST_A 3'h0
`define LCDHP_CODE_HOST_B 3'h1
`define LCDHP_CODE_STROBE 3'h3
`define LCDHP_CODE_M68K2  3'h5
`define LCDHP_CODE_GEN    3'h7
// endian strap values
`define LCDHP_ENDIAN_LE   1'b0
// wait states: base count plus extra while refresh holds the memory
`define LCDHP_WAIT_BASE   3'h2
`define LCDHP_WAIT_PANEL  3'h2
`define LCDHP_CNT_W       3
`endif

// [src/lcdhp_pkg.sv]
package lcdhp_pkg;
   typedef enum logic [2:0] {
      LCDHP_MODE_RESERVED = 3'h0,
      LCDHP_MODE_HOST_A   = 3'h1,
      LCDHP_MODE_HOST_B   = 3'h2,
      LCDHP_MODE_STROBE   = 3'h3,
      LCDHP_MODE_M68K2    = 3'h4,
      LCDHP_MODE_GEN1     = 3'h5,
      LCDHP_MODE_GEN2     = 3'h6
   } lcdhp_mode_type;

   typedef struct packed {
      logic [2:0] mode_strap;  // {bit2,bit1,bit0}
      logic       endian_strap;
      logic       bus_status_n;
   } lcdhp_strap_type;

   typedef struct packed {
      lcdhp_mode_type mode;
      logic           big_endian;
   } lcdhp_cfg_type;
endpackage

// [src/lcdhp_strap.sv]
`timescale 1ns/10ps
`include "lcdhp_map.svh"
// catches straps once after reset release, then holds them
module lcdhp_strap
   import lcdhp_pkg::*;
(
   input  wire logic            clk,      // host bus clock
   input  wire logic            rst_n,    // async reset, active low
   input  wire lcdhp_strap_type straps,   // synchronised strap levels
   output lcdhp_cfg_type        cfg,      // latched configuration
   output logic                 cfg_valid // configuration captured
);
   lcdhp_mode_type next_mode;

   // strap code to bus mode
   always_comb begin
      unique case (straps.mode_strap)
         `LCDHP_CODE_HOST_A: next_mode = LCDHP_MODE_HOST_A;
         `LCDHP_CODE_HOST_B: next_mode = LCDHP_MODE_HOST_B;
         `LCDHP_CODE_STROBE: next_mode = LCDHP_MODE_STROBE;
         `LCDHP_CODE_M68K2:  next_mode = LCDHP_MODE_M68K2;
         `LCDHP_CODE_GEN:    next_mode = straps.bus_status_n ? LCDHP_MODE_GEN2 : LCDHP_MODE_GEN1;
         default:            next_mode = LCDHP_MODE_RESERVED;
      endcase
   end

   // first edge after release captures, later edges hold
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg       <= '{mode: LCDHP_MODE_RESERVED, big_endian: 1'b0};
         cfg_valid <= 1'b0;
      end else if (!cfg_valid) begin
         cfg.mode       <= next_mode;
         cfg.big_endian <= (straps.endian_strap != `LCDHP_ENDIAN_LE);
         cfg_valid      <= 1'b1;
      end
   end
endmodule

// [dv/lcdhp_port_chk.sv]
`timescale 1ns/10ps
// pin-level checks on wait, select and strap capture
module lcdhp_port_chk (
   input wire logic       CLK,           // host clock
   input wire logic       RST_N,         // async reset
   input wire logic       CHIP_SELECT_N, // device select
   input wire logic       REFRESH_BUSY,  // refresh hold
   input wire logic       WAIT_N,        // wait, active low
   input wire logic       WAIT_OE,       // wait drive
   input wire logic       DATA_OE,       // data drive
   input wire logic [2:0] BUS_MODE,      // latched mode
   input wire logic       BIG_ENDIAN,    // latched order
   input wire logic       MODE_RESERVED  // reserved code
);
   logic [3:0] cnt;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // cycles since reset release, saturating once the straps are settled
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) cnt <= 4'h0;
      else if (cnt != 4'h8) cnt <= cnt + 4'h1;
   end
   chk_cfg_hold: assert property (cnt == 4'h8 |-> $stable(BUS_MODE) && $stable(BIG_ENDIAN))
      else $error("configuration moved after capture");
   chk_reserved_flag: assert property (cnt == 4'h8 |-> MODE_RESERVED == (BUS_MODE == 3'h0))
      else $error("reserved flag disagrees with mode");
   chk_mode_code: assert property (BUS_MODE <= 3'h6)
      else $error("mode outside the encoding");
   chk_wait_driven: assert property (!WAIT_N |-> WAIT_OE)
      else $error("wait asserted while not driven");
   chk_wait_min: assert property ($fell(WAIT_N) |-> !WAIT_N [*3])
      else $error("wait shorter than base count");
   chk_wait_bound: assert property ($fell(WAIT_N) |-> ##[1:80] WAIT_N)
      else $error("wait never ended");
   chk_release_oe: assert property ($rose(CHIP_SELECT_N) |-> ##[1:5] !WAIT_OE)
      else $error("wait not released after deselect");
   chk_oe_cause: assert property ($rose(WAIT_OE) |-> !$past(CHIP_SELECT_N))
      else $error("wait driven without select");
   chk_data_done: assert property (DATA_OE |-> WAIT_N)
      else $error("data driven before access done");
   chk_refresh_freeze: assert property ((REFRESH_BUSY && !WAIT_N) [*3] |=> !WAIT_N)
      else $error("wait ended during refresh");
   cover property ($rose(WAIT_N) && !CHIP_SELECT_N);
   cover property (REFRESH_BUSY && !WAIT_N);
   cover property (cnt == 4'h8 && BUS_MODE == 3'h3);
endmodule
bind lcdhp_port lcdhp_port_chk lcdhp_port_chk_inst (.CLK(CLK), .RST_N(RST_N), .CHIP_SELECT_N(CHIP_SELECT_N),
   .REFRESH_BUSY(REFRESH_BUSY), .WAIT_N(WAIT_N), .WAIT_OE(WAIT_OE), .DATA_OE(DATA_OE), .BUS_MODE(BUS_MODE),
   .BIG_ENDIAN(BIG_ENDIAN), .MODE_RESERVED(MODE_RESERVED));

// [dv/lcdhp_host_glue.sv]
`timescale 1ns/10ps
// host glue: select-gated AND turning the driven, released wait into an acknowledge
module lcdhp_host_glue (
   input  wire logic wait_n,        // device wait
   input  wire logic wait_oe,       // device drives wait
   input  wire logic chip_select_n, // device select
   output logic      xfer_ack       // acknowledge to host
);
   // host chip-select setup for the device window: writable, 16-bit, ended externally
   localparam logic       cs_read_only_flag   = 1'b0;
   localparam logic       cs_bus_width_flag   = 1'b1;
   localparam logic [2:0] cs_wait_state_field = 3'h7;
   // acknowledge pin function chosen by bit 0 of the host's port pin-select register
   localparam logic [7:0] pin_select          = 8'h01;
   logic                  ext_ack;
   // the device can end cycles only with that setup in place
   assign ext_ack  = !cs_read_only_flag && cs_bus_width_flag &&
                     (cs_wait_state_field == 3'h7) && pin_select[0];
   // only a driven, released wait under select ends the cycle
   assign xfer_ack = ext_ack && !chip_select_n && wait_oe && wait_n;
endmodule

// [dv/testbench.sv]
`timescale 1ns/10ps
// host cycles into the port with expected results
module testbench
   import lcdhp_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [2:0]  mode_strap = 3'h7;
   logic        endian_strap = 1'b0;
   logic        bus_status_n = 1'b0;
   logic        cs_n = 1'b1;
   logic [16:0] addr = 17'h0;
   logic        hi_wr_n = 1'b1;
   logic        lo_wr_n = 1'b1;
   logic        lo_rd_n = 1'b1;
   logic        rd_wr = 1'b1;
   logic [15:0] din = 16'h0;
   logic        refresh = 1'b0;
   logic        strobe = 1'b0;
   logic [15:0] dout, q;
   logic        data_oe, wait_n, wait_oe, big_endian, mode_res, ack;
   logic [2:0]  bus_mode;
   int          err_count = 0;
   int          n_compared = 0;
   int          cycles = 0;
   logic [16:0] ad [4] = '{17'h00000, 17'h13ffe, 17'h1ffe0, 17'h1fffe};

   // clock
   always #5 clk = ~clk;
   lcdhp_port lcdhp_port_inst (.CLK(clk), .RST_N(rst_n), .MODE_STRAP(mode_strap), .ENDIAN_STRAP(endian_strap),
      .BUS_STATUS_N(bus_status_n), .CHIP_SELECT_N(cs_n), .ADDR(addr), .HIGH_BYTE_WRITE_N(hi_wr_n),
      .LOW_BYTE_WRITE_N(lo_wr_n), .LOW_BYTE_READ_N(lo_rd_n), .READ_WRITE(rd_wr), .DATA_IN(din),
      .REFRESH_BUSY(refresh), .DATA_OUT(dout), .DATA_OE(data_oe), .WAIT_N(wait_n), .WAIT_OE(wait_oe),
      .BUS_MODE(bus_mode), .BIG_ENDIAN(big_endian), .MODE_RESERVED(mode_res));
   lcdhp_host_glue lcdhp_host_glue_inst (.wait_n(wait_n), .wait_oe(wait_oe), .chip_select_n(cs_n), .xfer_ack(ack));

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tend(input string nm);
      $display("test %s done, mismatches %0d", nm, err_count);
   endtask
   // reset with a strap set held well past the capture edge
   task automatic rst(input logic [2:0] code, input logic en, input logic bs);
      @(negedge clk);
      rst_n = 1'b0;
      {mode_strap, endian_strap, bus_status_n} = {code, en, bs};
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask
   // one host cycle held until acknowledge; be is {high, low} lane
   task automatic acc(input logic w, input logic [16:0] a, input logic [15:0] d, input logic [1:0] be);
      int   n;
      logic lo;
      n = 0;
      lo = 1'b0;
      @(negedge clk);
      {cs_n, din} = {1'b0, d};
      addr = strobe ? {a[16:1], ~be[0]} : a;
      if (strobe) {bus_status_n, rd_wr, hi_wr_n} = {1'b0, !w, ~be[1]};
      else if (w) {hi_wr_n, lo_wr_n} = ~be;
      else {rd_wr, lo_rd_n} = ~be;
      while (!(ack && lo) && n < 80) begin
         @(negedge clk);
         lo = lo | !wait_n;
         n++;
      end
      q = dout;
      chk("wait seen", 16'h1, 16'(lo));
      chk("acknowledge", 16'h1, 16'(ack));
      chk("data drive", 16'(!w), 16'(data_oe));
      @(negedge clk);
      {cs_n, hi_wr_n, lo_wr_n, lo_rd_n, rd_wr, addr[0]} = 6'h3f;
      if (strobe) bus_status_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("wait released", 16'h0, 16'(wait_oe));
      chk("data released", 16'h0, 16'(data_oe));
   endtask
   function automatic lcdhp_mode_type expm(input logic [2:0] c, input logic bs);
      case (c)
         3'h0: expm = LCDHP_MODE_HOST_A;
         3'h1: expm = LCDHP_MODE_HOST_B;
         3'h3: expm = LCDHP_MODE_STROBE;
         3'h5: expm = LCDHP_MODE_M68K2;
         3'h7: expm = bs ? LCDHP_MODE_GEN2 : LCDHP_MODE_GEN1;
         default: expm = LCDHP_MODE_RESERVED;
      endcase
   endfunction

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         err_count++;
         results();
      end
   end

   // main sequence
   initial begin
      for (int i = 0; i < 16; i++) begin
         rst(i[3:1], !i[1], i[0]);
         chk("mode", 16'(expm(i[3:1], i[0])), 16'(bus_mode));
         chk("reserved", 16'(expm(i[3:1], i[0]) == LCDHP_MODE_RESERVED), 16'(mode_res));
         chk("endian", 16'(!i[1]), 16'(big_endian));
      end
      tend("straps");
      rst(3'h7, 1'b0, 1'b0);
      {mode_strap, endian_strap} = 4'h1;
      repeat (6) @(negedge clk);
      chk("held mode", 16'(LCDHP_MODE_GEN1), 16'(bus_mode));
      chk("held endian", 16'h0, 16'(big_endian));
      acc(1'b1, 17'h10, 16'h1234, 2'h3);
      acc(1'b1, 17'h10, 16'hffab, 2'h1);
      acc(1'b0, 17'h10, 16'h0, 2'h3);
      chk("lane write", 16'h12ab, q);
      tend("generic");
      for (int i = 0; i < 4; i++) acc(1'b1, ad[i], 16'h5a00 + 16'(i), 2'h3);
      acc(1'b1, 17'h14000, 16'h7777, 2'h3);
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, ad[i], 16'h0, 2'h3);
         chk("window", 16'h5a00 + 16'(i), q);
      end
      acc(1'b0, 17'h14000, 16'hffff, 2'h3);
      chk("unmapped", 16'h0, q);
      tend("window");
      refresh = 1'b1;
      fork
         acc(1'b0, 17'h10, 16'h0, 2'h3);
         begin
            repeat (20) @(negedge clk);
            chk("refresh hold", 16'h0, 16'(wait_n));
            refresh = 1'b0;
         end
      join
      chk("refresh read", 16'h12ab, q);
      tend("refresh");
      rst(3'h3, 1'b1, 1'b1);
      strobe = 1'b1;
      chk("big endian", 16'h1, 16'(big_endian));
      acc(1'b1, 17'h20, 16'hc3a5, 2'h3);
      acc(1'b0, 17'h20, 16'h0, 2'h3);
      chk("strobe read", 16'hc3a5, q);
      tend("strobe");
      results();
   end
endmodule
